// *** rtl/aci_pkg.sv ***
// types of the converter command interface
package aci_pkg;

  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_ADDR = 3'h1,
    LK_ADR_ACK = 3'h3,
    LK_RD_BYTE = 3'h2,
    LK_RD_ACK = 3'h6,
    LK_WR_BYTE = 3'h7,
    LK_WR_ACK = 3'h5,
    LK_SKIP = 3'h4
  } aci_link_t;

  typedef enum logic [1:0] {
    CV_OFF = 2'h0,
    CV_ACQ = 2'h1,
    CV_RUN = 2'h3
  } aci_conv_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_f;
    logic sda_f;
    logic [1:0] scl_bk;
    logic [1:0] sda_bk;
    aci_link_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic byte_sel;
    logic wr_done;
    logic sda_oe;
    logic hs_mode;
    logic full_sd;
    logic [15:0] tx;
    logic [3:0] ptr;
    logic [7:0] cfg;
    aci_conv_t cv;
    logic [3:0] cnt;
    logic sample;
    logic [1:0] chan;
    logic [15:0] result;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aci_state_t;

endpackage

// *** rtl/aci_regs.svh ***
// register offsets, config fields, reset values and timing counts of the converter interface
`ifndef ACI_REGS_SVH
`define ACI_REGS_SVH

`define ACI_ADDR_CFG 8'h00
`define ACI_ADDR_STAT 8'h04
`define ACI_ADDR_RES 8'h08

`define ACI_CFG_RESET 8'hf0
`define ACI_CFG_CHEN_HI 7
`define ACI_CFG_CHEN_LO 4
`define ACI_CFG_FILT_BIT 2

`define ACI_HS_CODE 5'h01

`define ACI_RESP_OKAY 2'h0
`define ACI_RESP_SLVERR 2'h2

`define ACI_CLK_NS 100
`define ACI_ACQ_NS 600
`define ACI_CONV_NS 1000
`define ACI_ACQ_CYC ((`ACI_ACQ_NS + `ACI_CLK_NS - 1) / `ACI_CLK_NS)
`define ACI_CONV_CYC ((`ACI_CONV_NS + `ACI_CLK_NS - 1) / `ACI_CLK_NS)
`define ACI_BLANK_CYC 2'h2

`endif

// *** rtl/aci_top.sv ***
// two-wire command interface of a four-channel converter, with an axi4-lite register port
`timescale 1ns/10ps
`default_nettype none
`include "aci_regs.svh"

//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - after start, shift in address and direction
// - acknowledge own address, else stay idle
// - direction 0 writes, 1 reads
// - nine clocks per byte, receiver acknowledges
// - data changes only while clock low
// - power-up: full shutdown, all channels enabled
// - write carries exactly one configuration byte
// - each result is two bytes
// - results continue while master keeps reading
// - two zeros, channel tag, trailing zeros
// - ninth rise starts power-up, then convert
// - ack of second byte starts next conversion
// - nack of second byte stops converting
// - further conversions take next enabled channel
// - stop gives full shutdown
// - high-speed master code is never acknowledged
// - repeated start then address, acknowledged
// - high-speed mode lasts until stop
// - enabled channels converted lowest first, ascending
// - conversion about 1 us, then shutdown
// - config bit two bypasses line filters
module aci_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h28,
  parameter int RES_BITS = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // two-wire link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // converter core
  output logic adc_power_on,
  output logic adc_sample,
  output logic [1:0] adc_channel,
  input wire logic [11:0] adc_result,
  // power and mode state
  output logic full_shutdown,
  output logic hs_mode
);

  localparam int ACQ_C = `ACI_ACQ_CYC;
  localparam int CONV_C = `ACI_CONV_CYC;
  localparam logic [3:0] ACQ_LD = 4'(ACQ_C - 1);
  localparam logic [3:0] CONV_LD = 4'(CONV_C - 1);
  // narrower variants return the low result bits as zeros
  localparam logic [11:0] RES_MASK = 12'hfff << (12 - RES_BITS);

  aci_pkg::aci_state_t s;
  aci_pkg::aci_state_t n;
  logic byp;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic start_c;
  logic stop_c;
  logic conv_start;
  logic rd_ack_rise;
  logic wr_store;

  // lowest enabled channel above cur, wrapping; cur of 3 yields the lowest overall
  function automatic logic [1:0] next_chan(input logic [3:0] en, input logic [1:0] cur);
    logic [1:0] r;
    logic [1:0] c;
    logic found;
    r = 2'h0;
    found = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      c = cur + 2'(i);
      if (en[c] && !found) begin
        r = c;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    n = s;
    conv_start = 1'b0;
    rd_ack_rise = 1'b0;
    wr_store = 1'b0;
    byp = s.cfg[`ACI_CFG_FILT_BIT];
    // pin synchronisers
    n.scl_s1 = scl_i;
    n.scl_s2 = s.scl_s1;
    n.sda_s1 = sda_i;
    n.sda_s2 = s.sda_s1;
    // filter: after an accepted change, further changes are blanked for a while;
    // no added latency, but a lone spike on a quiet line still passes
    if (byp || s.scl_bk == 2'h0) begin
      n.scl_f = s.scl_s2;
      n.scl_bk = (!byp && s.scl_s2 != s.scl_f) ? `ACI_BLANK_CYC : 2'h0;
    end else begin
      n.scl_bk = s.scl_bk - 2'h1;
    end
    if (byp || s.sda_bk == 2'h0) begin
      n.sda_f = s.sda_s2;
      n.sda_bk = (!byp && s.sda_s2 != s.sda_f) ? `ACI_BLANK_CYC : 2'h0;
    end else begin
      n.sda_bk = s.sda_bk - 2'h1;
    end
    scl_rise = n.scl_f && !s.scl_f;
    scl_fall = !n.scl_f && s.scl_f;
    sda_rise = n.sda_f && !s.sda_f;
    sda_fall = !n.sda_f && s.sda_f;
    // data edges while clock stays high are start and stop
    start_c = s.scl_f && n.scl_f && sda_fall;
    stop_c = s.scl_f && n.scl_f && sda_rise;

    // axi4-lite slave
    n.sample = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wstb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `ACI_RESP_OKAY;
      if (n.awaddr == `ACI_ADDR_CFG) begin
        if (n.wstb0) begin
          n.cfg = n.wdata;
        end
      end else if (n.awaddr != `ACI_ADDR_STAT && n.awaddr != `ACI_ADDR_RES) begin
        n.bresp = `ACI_RESP_SLVERR;
      end
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = `ACI_RESP_OKAY;
      case (s_axi_araddr)
        `ACI_ADDR_CFG: n.rdata = {24'h0, s.cfg};
        `ACI_ADDR_STAT: n.rdata = {24'h0, s.hs_mode, s.full_sd, s.cv != aci_pkg::CV_OFF,
          s.chan, s.st};
        `ACI_ADDR_RES: n.rdata = {16'h0, s.result};
        default: begin
          n.rdata = 32'h0;
          n.rresp = `ACI_RESP_SLVERR;
        end
      endcase
    end

    // link state machine
    if (stop_c) begin
      n.st = aci_pkg::LK_IDLE;
      n.sda_oe = 1'b0;
      n.full_sd = 1'b1;
      n.hs_mode = 1'b0;
    end else if (start_c) begin
      // also a repeated start, e.g. after the high-speed code
      n.st = aci_pkg::LK_ADDR;
      n.sda_oe = 1'b0;
      n.bitcnt = 4'h0;
    end else begin
      case (s.st)
        aci_pkg::LK_ADDR: begin
          if (scl_rise) begin
            n.shreg = {s.shreg[6:0], n.sda_f};
            n.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == 4'h8) begin
            n.bitcnt = 4'h0;
            if (s.shreg[7:1] == SLAVE_ADDR) begin
              n.st = aci_pkg::LK_ADR_ACK;
              n.sda_oe = 1'b1;
              n.rw = s.shreg[0];
              n.full_sd = 1'b0;
            end else if (s.shreg[7:3] == `ACI_HS_CODE) begin
              n.st = aci_pkg::LK_SKIP;
              n.hs_mode = 1'b1;
            end else begin
              n.st = aci_pkg::LK_SKIP;
            end
          end
        end
        aci_pkg::LK_ADR_ACK: begin
          if (scl_rise) begin
            n.bitcnt = 4'h9;
            if (s.rw) begin
              conv_start = 1'b1;
              n.chan = next_chan(s.cfg[7:4], 2'h3);
              // framed now, so the result merged at conversion end is kept
              n.tx = {2'h0, n.chan, 12'h0};
              n.byte_sel = 1'b0;
            end
          end else if (scl_fall && s.bitcnt == 4'h9) begin
            n.bitcnt = 4'h0;
            if (s.rw) begin
              n.st = aci_pkg::LK_RD_BYTE;
              n.sda_oe = 1'b1;
              n.ptr = 4'h1;
            end else begin
              n.st = aci_pkg::LK_WR_BYTE;
              n.sda_oe = 1'b0;
              n.wr_done = 1'b0;
            end
          end
        end
        aci_pkg::LK_RD_BYTE: begin
          if (scl_rise) begin
            n.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (s.bitcnt == 4'h8) begin
              n.st = aci_pkg::LK_RD_ACK;
              n.sda_oe = 1'b0;
              n.bitcnt = 4'h0;
            end else begin
              // open drain: a one is sent by releasing the line
              n.sda_oe = !s.tx[~s.ptr];
              n.ptr = s.ptr + 4'h1;
            end
          end
        end
        aci_pkg::LK_RD_ACK: begin
          if (scl_rise && s.bitcnt != 4'h9) begin
            rd_ack_rise = 1'b1;
            if (n.sda_f) begin
              n.st = aci_pkg::LK_IDLE;
            end else begin
              n.bitcnt = 4'h9;
              n.byte_sel = !s.byte_sel;
              if (s.byte_sel) begin
                conv_start = 1'b1;
                n.chan = next_chan(s.cfg[7:4], s.chan);
                n.tx = {2'h0, n.chan, 12'h0};
              end
            end
          end else if (scl_fall && s.bitcnt == 4'h9) begin
            n.st = aci_pkg::LK_RD_BYTE;
            n.bitcnt = 4'h0;
            if (!s.byte_sel) begin
              n.sda_oe = 1'b1;
              n.ptr = 4'h1;
            end else begin
              n.sda_oe = !s.tx[~s.ptr];
              n.ptr = s.ptr + 4'h1;
            end
          end
        end
        aci_pkg::LK_WR_BYTE: begin
          if (scl_rise) begin
            n.shreg = {s.shreg[6:0], n.sda_f};
            n.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == 4'h8) begin
            n.bitcnt = 4'h0;
            if (!s.wr_done) begin
              wr_store = 1'b1;
              n.cfg = s.shreg;
              n.wr_done = 1'b1;
              n.st = aci_pkg::LK_WR_ACK;
              n.sda_oe = 1'b1;
            end else begin
              // only one byte fits the configuration; later bytes are not acknowledged
              n.st = aci_pkg::LK_SKIP;
            end
          end
        end
        aci_pkg::LK_WR_ACK: begin
          if (scl_rise) begin
            n.bitcnt = 4'h9;
          end else if (scl_fall && s.bitcnt == 4'h9) begin
            n.st = aci_pkg::LK_WR_BYTE;
            n.sda_oe = 1'b0;
            n.bitcnt = 4'h0;
          end
        end
        aci_pkg::LK_SKIP: n.sda_oe = 1'b0;
        aci_pkg::LK_IDLE: n.sda_oe = 1'b0;
        default: begin
          n.st = aci_pkg::LK_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // conversion sequencer; a new start restarts a conversion under way
    if (conv_start) begin
      n.cv = aci_pkg::CV_ACQ;
      n.cnt = ACQ_LD;
    end else begin
      case (s.cv)
        aci_pkg::CV_ACQ: begin
          if (s.cnt == 4'h0) begin
            n.cv = aci_pkg::CV_RUN;
            n.sample = 1'b1;
            n.cnt = CONV_LD;
          end else begin
            n.cnt = s.cnt - 4'h1;
          end
        end
        aci_pkg::CV_RUN: begin
          if (s.cnt == 4'h0) begin
            n.cv = aci_pkg::CV_OFF;
            // with no channel enabled the frame still goes out, carrying channel 0 and its result
            n.tx[11:0] = adc_result & RES_MASK;
            n.result = {2'h0, s.chan, adc_result & RES_MASK};
          end else begin
            n.cnt = s.cnt - 4'h1;
          end
        end
        aci_pkg::CV_OFF: n.cnt = 4'h0;
        default: n.cv = aci_pkg::CV_OFF;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, scl_f: 1'b1,
        sda_f: 1'b1, st: aci_pkg::LK_IDLE, cv: aci_pkg::CV_OFF, full_sd: 1'b1,
        cfg: `ACI_CFG_RESET, default: '0};
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign sda_o = 1'b0;
  assign sda_oe = s.sda_oe;
  assign adc_power_on = s.cv != aci_pkg::CV_OFF;
  assign adc_sample = s.sample;
  assign adc_channel = s.chan;
  assign full_shutdown = s.full_sd;
  assign hs_mode = s.hs_mode;

  //////////////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_ack_drive: assert property (
    s.st == aci_pkg::LK_ADR_ACK |-> s.sda_oe)
    else $error("address acknowledge not driven");
  a_idle_quiet: assert property (
    (s.st == aci_pkg::LK_IDLE || s.st == aci_pkg::LK_SKIP) |-> !s.sda_oe)
    else $error("data line driven while not selected");
  a_ack_conv: assert property (
    rd_ack_rise && !n.sda_f && s.byte_sel |-> conv_start)
    else $error("ack of second byte started no conversion");
  a_nack_stop: assert property (
    rd_ack_rise && n.sda_f |-> !conv_start ##1 (s.st == aci_pkg::LK_IDLE))
    else $error("nack did not end the read");
  a_acq_time: assert property (
    $rose(adc_power_on) |-> !adc_sample ##ACQ_C adc_sample)
    else $error("acquisition length wrong");
  a_conv_off: assert property (
    adc_sample |-> adc_power_on[*2] ##(CONV_C - 1) !adc_power_on)
    else $error("converter not shut down after conversion");
  a_stop_sd: assert property (
    stop_c |=> s.full_sd && s.st == aci_pkg::LK_IDLE)
    else $error("stop did not give full shutdown");
  a_hs_exit: assert property (
    stop_c |=> !hs_mode)
    else $error("high-speed mode kept after stop");
  a_chan_ok: assert property (
    conv_start && s.cfg[7:4] != 4'h0 |=> (s.cfg[7:4] & (4'h1 << s.chan)) != 4'h0)
    else $error("conversion on a disabled channel");
  a_head_zero: assert property (
    s.st == aci_pkg::LK_RD_BYTE |-> s.tx[15:14] == 2'h0)
    else $error("result lacks leading zeros");
  a_cfg_store: assert property (
    wr_store |=> s.cfg == $past(s.shreg))
    else $error("configuration byte not stored");

  c_two_byte_read: cover property (rd_ack_rise && !n.sda_f && s.byte_sel);
  c_cfg_write: cover property (wr_store);
  c_hs_entry: cover property ($rose(hs_mode));
  c_stop: cover property (stop_c && !s.full_sd);

endmodule
`default_nettype wire

// *** testbench/aci_i2c_master.sv ***
// two-wire bus master model facing the converter interface
`timescale 1ns/10ps
`default_nettype none
module aci_i2c_master (
  // strobe clock
  input wire logic aclk,
  // link
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  // last byte seen, as {ack bit, byte}
  output logic rx_stb,
  output logic [8:0] rx_val
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rx_stb = 1'b0;
    rx_val = 9'h000;
  end
  // start or repeated start; a new direction always comes through here
  task automatic start();
    sda_low <= 1'b0;
    #100;
    scl <= 1'b1;
    #400;
    sda_low <= 1'b1;
    #400;
    scl <= 1'b0;
  endtask
  // clock is left high afterwards, standing still between frames
  task automatic stop();
    sda_low <= 1'b1;
    #100;
    scl <= 1'b1;
    #400;
    sda_low <= 1'b0;
    #400;
  endtask
  // a read byte releases data and answers mack in the ninth slot
  task automatic xfer(input logic [7:0] wb, input logic rd, input logic mack);
    logic [8:0] tx;
    logic [8:0] got;
    tx = rd ? {8'hff, mack} : {wb, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      #100;
      sda_low <= !tx[i];
      #400;
      scl <= 1'b1;
      #200;
      got[i] = sda;
      #100;
      // ninth clock held high while the converter powers up
      if (i == 0) #2000;
      scl <= 1'b0;
    end
    @(posedge aclk);
    rx_val <= {got[0], got[8:1]};
    rx_stb <= 1'b1;
    @(posedge aclk);
    rx_stb <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench/aci_top_test.sv ***
// self-checking bench of the converter command interface
`timescale 1ns/10ps
`default_nettype none
module aci_top_test;
  typedef struct {string nm; logic [33:0] v;} aci_exp_t;
  localparam logic [6:0] ADR = 7'h28;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, scl, sda_low, sda_o, sda_oe;
  logic pwr, smp, fsd, hs, rx_stb;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rng;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, adc_channel;
  logic [11:0] adc_result;
  logic [8:0] rx_val;
  logic [11:0] res_tab [4];
  aci_exp_t exp_q [$];
  int error_cnt, checked, pwr_cnt, smp_cnt;
  wire logic sda;
  // open drain with pull-up
  assign sda = !sda_low && !sda_oe;

  aci_top #(.SLAVE_ADDR(ADR), .RES_BITS(12)) i_aci_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .adc_power_on(pwr), .adc_sample(smp), .adc_channel(adc_channel),
    .adc_result(adc_result), .full_shutdown(fsd), .hs_mode(hs));
  aci_i2c_master i_aci_i2c_master (.aclk(aclk), .sda(sda), .scl(scl), .sda_low(sda_low),
    .rx_stb(rx_stb), .rx_val(rx_val));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = !aclk;
  end
  // converter core stand-in: one result per channel
  always @(posedge aclk) begin
    adc_result <= res_tab[adc_channel];
    if (pwr === 1'b1) pwr_cnt <= pwr_cnt + 1;
    if (smp === 1'b1) smp_cnt <= smp_cnt + 1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("unexpected pending notes: expected 0, seen %0d", exp_q.size());
    end
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (e !== g) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic cmp(input logic [33:0] g);
    aci_exp_t e;
    if (exp_q.size() == 0) begin
      error_cnt++;
      $display("unexpected result: expected none, seen %h", g);
      return;
    end
    e = exp_q.pop_front();
    checked++;
    if (e.v !== g) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", e.nm, e.v, g);
    end
  endtask
  // handshakes are sampled at the falling edge, so they match the next rising edge
  always @(negedge aclk) begin
    if (bvalid && bready) cmp({bresp, 32'h0});
    if (rvalid && rready) cmp({rresp, rdata});
    if (rx_stb) cmp({25'h0, rx_val});
  end
  task automatic waited(inout int n);
    n++;
    if (n > 100) begin
      error_cnt++;
      $display("unexpected wait: expected handshake, seen none");
      report_and_stop();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, b;
    int n;
    exp_q.push_back('{"write response", {r, 32'h0}});
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (b) begin
      @(negedge aclk);
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      if (bvalid) b = 1'b0;
      waited(n);
      @(posedge aclk);
      awvalid <= aw;
      wvalid <= w;
      bready <= b;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    logic ar, r;
    int n;
    exp_q.push_back('{"read data", e});
    ar = 1'b1;
    r = 1'b1;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r) begin
      @(negedge aclk);
      if (arready) ar = 1'b0;
      if (rvalid) r = 1'b0;
      waited(n);
      @(posedge aclk);
      arvalid <= ar;
      rready <= r;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  function automatic logic [1:0] nxt(input logic [3:0] m, input logic [1:0] c);
    logic [1:0] r;
    r = 2'd0;
    for (int i = 4; i >= 1; i--) if (m[2'(c + i)]) r = 2'(c + i);
    return r;
  endfunction
  task automatic i2c_byte(input logic [7:0] b, input logic ack);
    exp_q.push_back('{"serial byte", {25'h0, ack, b}});
    i_aci_i2c_master.xfer(b, 1'b0, 1'b0);
  endtask
  task automatic rd_op(input logic [3:0] m, input int n);
    logic [1:0] ch;
    logic [15:0] w;
    int p0, s0;
    ch = nxt(m, 2'd3);
    p0 = pwr_cnt;
    s0 = smp_cnt;
    i_aci_i2c_master.start();
    i2c_byte({ADR, 1'b1}, 1'b0);
    chk("shutdown flag", 16'h0, fsd);
    chk("data out level", 16'h0, sda_o);
    for (int k = 0; k < n; k++) begin
      w = {2'b00, ch, res_tab[ch]};
      exp_q.push_back('{"result high", {26'h0, w[15:8]}});
      i_aci_i2c_master.xfer(8'hff, 1'b1, 1'b0);
      exp_q.push_back('{"result low", {25'h0, k == n - 1, w[7:0]}});
      i_aci_i2c_master.xfer(8'hff, 1'b1, k == n - 1);
      ch = nxt(m, ch);
    end
    i_aci_i2c_master.stop();
    repeat (30) @(posedge aclk);
    chk("power cycles", 16'(16 * n), 16'(pwr_cnt - p0));
    chk("sample pulses", 16'(n), 16'(smp_cnt - s0));
    chk("shutdown flag", 16'h1, fsd);
    chk("high speed flag", 16'h0, hs);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    adc_result = 12'h000;
    aresetn = 1'b0;
    rng = 32'h0000002b;
    {error_cnt, checked, pwr_cnt, smp_cnt} = 128'h0;
    for (int i = 0; i < 4; i++) res_tab[i] = 12'h000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("shutdown flag", 16'h1, fsd);
    chk("high speed flag", 16'h0, hs);
    axi_rd(8'h00, {2'h0, 32'hf0});
    axi_rd(8'h04, {2'h0, 32'h40});
    axi_rd(8'h0c, {2'h2, 32'h0});
    axi_wr(8'h0c, 32'h55, 2'h2);
    axi_wr(8'h04, 32'h55, 2'h0);
    rd_op(4'hf, 5);
    i_aci_i2c_master.start();
    i2c_byte({ADR ^ 7'h01, 1'b1}, 1'b1);
    chk("shutdown flag", 16'h1, fsd);
    i_aci_i2c_master.stop();
    i_aci_i2c_master.start();
    i2c_byte({ADR, 1'b0}, 1'b0);
    i2c_byte(8'ha4, 1'b0);
    i2c_byte(8'h10, 1'b1);
    i_aci_i2c_master.stop();
    axi_rd(8'h00, {2'h0, 32'ha4});
    rd_op(4'ha, 3);
    // channels 0 and 2 with the line filters active for the high-speed read
    axi_wr(8'h00, 32'h50, 2'h0);
    i_aci_i2c_master.start();
    i2c_byte(8'h0b, 1'b1);
    chk("high speed flag", 16'h1, hs);
    rd_op(4'h5, 2);
    // every channel mask, random results and random low config bits
    for (int m = 0; m < 16; m++) begin
      for (int i = 0; i < 4; i++) begin
        rng = xorshift(rng);
        res_tab[i] = rng[11:0];
      end
      axi_wr(8'h00, {24'h0, 4'(m), rng[15:12]}, 2'h0);
      rd_op(4'(m), 2);
    end
    axi_rd(8'h08, {2'h0, 16'h0, 4'h1, res_tab[1]});
    report_and_stop();
  end
endmodule
`default_nettype wire
